// >>> verilog/dmt_pkg.sv
package dmt_pkg;
	// Register indices; byte address is four times the index (low 32 bits)
	localparam logic [31:0] IDX_START = 32'hFFFFF710;
	localparam logic [31:0] IDX_CSR0 = 32'hFFFFF712;
	localparam logic [31:0] IDX_CNT0 = 32'hFFFFF714;
	localparam logic [31:0] IDX_COR0 = 32'hFFFFF716;
	localparam logic [31:0] IDX_CSR1 = 32'hFFFFF718;
	localparam logic [31:0] IDX_CNT1 = 32'hFFFFF71A;
	localparam logic [31:0] IDX_COR1 = 32'hFFFFF71C;

	// Field positions
	localparam int CSR_FLAG_BIT = 7;
	localparam int CSR_IE_BIT = 6;
	localparam int CSR_CKS_HI = 1;
	localparam int CSR_CKS_LO = 0;
	localparam int START_RUN_HI = 1;

	// Values after reset, and the counter value loaded on a match
	localparam logic [1:0] START_RST = 2'h0;
	localparam logic [1:0] CKS_RST = 2'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MATCH_VAL = 16'h0000;
	localparam logic [15:0] COR_RST = 16'hFFFF;
	localparam logic [8:0] PRESC_RST = 9'h000;

	// Prescaler taps for divide by 8, 32, 128, 512
	localparam int PRESC_W = 9;
	localparam logic [8:0] TICK_MASK [4] = '{9'h007, 9'h01F, 9'h07F, 9'h1FF};

	// Bus data-phase length in clock cycles
	localparam int ACC_SHORT_CYC = 4;
	localparam int ACC_LONG_CYC = 8;

	// AHB encodings
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;

	typedef enum logic [2:0] {
		DMT_IDLE = 3'b001,
		DMT_WAIT = 3'b010,
		DMT_LAST = 3'b100
	} dmt_bus_state_type;
endpackage : dmt_pkg

// >>> verilog/dmt_channel.sv
`timescale 1ns/10ps
module dmt_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Initialisation
	input wire logic standby,
	input wire logic manual_rst,
	// Timing
	input wire logic run,
	input wire logic [3:0] ticks,
	// Register writes, byte lanes, and the flag read strobe
	input wire logic [1:0] csr_be,
	input wire logic [1:0] cnt_be,
	input wire logic [1:0] cor_be,
	input wire logic [15:0] wdata,
	input wire logic flag_read,
	// State
	output logic [15:0] count,
	output logic [15:0] constant,
	output logic [15:0] csr,
	output logic match,
	output logic irq
);
	logic flag;
	logic ie;
	logic seen;
	logic [1:0] cks;
	logic tick;

	assign tick = ticks[cks]; // [RULE2]
	// Compare is sampled at the tick, so the clear lands one tick after equality
	assign match = run && tick && (count == constant); // [RULE15]

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= dmt_pkg::CNT_RST;
		end else if (standby) begin
			count <= dmt_pkg::CNT_RST; // [RULE12]
		end else if (match) begin
			count <= dmt_pkg::CNT_MATCH_VAL; // [RULE5] [RULE16]
		end else if (|cnt_be) begin
			// Unwritten byte keeps its old value, nothing increments [RULE17] [RULE18]
			if (cnt_be[0]) begin
				count[7:0] <= wdata[7:0];
			end
			if (cnt_be[1]) begin
				count[15:8] <= wdata[15:8];
			end
		end else if (run && tick) begin
			count <= count + 16'h0001; // [RULE4] [RULE19]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			constant <= dmt_pkg::COR_RST;
		end else if (standby) begin
			constant <= dmt_pkg::COR_RST; // [RULE13]
		end else begin
			if (cor_be[0]) begin
				constant[7:0] <= wdata[7:0];
			end
			if (cor_be[1]) begin
				constant[15:8] <= wdata[15:8];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ie <= 1'b0;
			cks <= dmt_pkg::CKS_RST;
		end else if (standby || manual_rst) begin
			ie <= 1'b0; // [RULE11]
			cks <= dmt_pkg::CKS_RST;
		end else if (csr_be[0]) begin
			ie <= wdata[dmt_pkg::CSR_IE_BIT]; // [RULE8]
			cks <= wdata[dmt_pkg::CSR_CKS_HI:dmt_pkg::CSR_CKS_LO];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag <= 1'b0;
		end else if (standby || manual_rst) begin
			flag <= 1'b0;
		end else if (match) begin
			flag <= 1'b1; // [RULE5]
		end else if (csr_be[0] && !wdata[dmt_pkg::CSR_FLAG_BIT] && seen) begin
			flag <= 1'b0; // [RULE7]
		end
	end

	// Arms the clear only after software has seen the flag set
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seen <= 1'b0;
		end else if (standby || manual_rst) begin
			seen <= 1'b0;
		end else if (flag_read) begin
			seen <= 1'b1; // [RULE7]
		end else if (csr_be[0]) begin
			seen <= 1'b0;
		end
	end

	assign csr = {8'h00, flag, ie, 4'h0, cks}; // [RULE10]
	assign irq = flag && ie; // [RULE6] [RULE20]
endmodule : dmt_channel

// >>> verilog/dmt_timer.sv
// Function
// RULE1: Two channels, 16-bit counter and constant
// RULE2: Clock select picks divide 8/32/128/512
// RULE3: Start register bit per channel runs counter
// RULE4: Running counter increments on each selected tick
// RULE5: Match clears counter, sets match flag
// RULE6: Interrupt when flag and enable both set
// RULE7: Flag cleared by writing zero after read
// RULE8: Bit 6 is interrupt enable, reset 0
// RULE9: Start bits 15..2 read zero
// RULE10: Status bits 15..8, 5..2 read zero
// RULE11: Start and status zeroed by reset, standby
// RULE12: Counter zeroed by reset/standby, not manual
// RULE13: Constant resets to all ones, manual keeps
// RULE14: Byte, word, long accesses with fixed latency
// RULE15: Match acts on tick after equality
// RULE16: Match clear beats counter write
// RULE17: Word write beats increment
// RULE18: Byte write beats increment, other byte kept
// RULE19: Halted counter holds its value
// RULE20: Interrupt level held until flag or enable cleared
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
module dmt_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Power control
	input wire logic standby,
	input wire logic manual_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Interrupt requests
	output logic [1:0] match_irq
);
	dmt_pkg::dmt_bus_state_type state;
	logic [2:0] wcnt;
	logic [29:0] ph_addr;
	logic [1:0] ph_lane;
	logic [2:0] ph_size;
	logic ph_write;
	logic capture;
	logic commit;
	logic rd_load;
	logic [1:0] be;
	logic [31:0] rd_mux;
	logic [1:0] run;
	logic [8:0] presc;
	logic [3:0] ticks;
	logic hit_start;
	logic [1:0] hit_csr;
	logic [1:0] hit_cnt;
	logic [1:0] hit_cor;
	logic [15:0] cnt [2];
	logic [15:0] cor [2];
	logic [15:0] csr [2];
	logic [1:0] match;

	assign capture = hsel && htrans[1] && hready;
	assign commit = (state == dmt_pkg::DMT_LAST) && ph_write;
	assign rd_load = (state == dmt_pkg::DMT_WAIT) && (wcnt == 3'h0);
	assign hreadyout = (state != dmt_pkg::DMT_WAIT);
	assign hresp = 1'b0;

	// Data phase length depends on access size [RULE14]
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= dmt_pkg::DMT_IDLE;
		end else begin
			case (state)
				dmt_pkg::DMT_IDLE: begin
					if (capture) begin
						state <= dmt_pkg::DMT_WAIT;
					end
				end
				dmt_pkg::DMT_WAIT: begin
					if (wcnt == 3'h0) begin
						state <= dmt_pkg::DMT_LAST;
					end
				end
				dmt_pkg::DMT_LAST: begin
					if (capture) begin
						state <= dmt_pkg::DMT_WAIT;
					end else begin
						state <= dmt_pkg::DMT_IDLE;
					end
				end
				default: begin
					state <= dmt_pkg::DMT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wcnt <= 3'h0;
		end else if (capture) begin
			if (hsize == dmt_pkg::HSIZE_BYTE || hsize == dmt_pkg::HSIZE_HALF) begin
				wcnt <= 3'(dmt_pkg::ACC_SHORT_CYC - 2); // [RULE14]
			end else begin
				wcnt <= 3'(dmt_pkg::ACC_LONG_CYC - 2); // [RULE14]
			end
		end else if (state == dmt_pkg::DMT_WAIT && wcnt != 3'h0) begin
			wcnt <= wcnt - 3'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ph_addr <= 30'h0;
			ph_lane <= 2'h0;
			ph_size <= 3'h0;
			ph_write <= 1'b0;
		end else if (capture) begin
			ph_addr <= haddr[31:2];
			ph_lane <= haddr[1:0];
			ph_size <= hsize;
			ph_write <= hwrite;
		end
	end

	// Registers live in the low half of each word; upper lanes are dropped
	always_comb begin
		be = 2'b00;
		if (ph_size == dmt_pkg::HSIZE_BYTE) begin
			if (ph_lane == 2'h0) begin
				be = 2'b01;
			end else if (ph_lane == 2'h1) begin
				be = 2'b10;
			end
		end else if (ph_size == dmt_pkg::HSIZE_HALF) begin
			if (!ph_lane[1]) begin
				be = 2'b11;
			end
		end else begin
			be = 2'b11;
		end
	end

	assign hit_start = (ph_addr == dmt_pkg::IDX_START[29:0]);
	assign hit_csr = {ph_addr == dmt_pkg::IDX_CSR1[29:0], ph_addr == dmt_pkg::IDX_CSR0[29:0]};
	assign hit_cnt = {ph_addr == dmt_pkg::IDX_CNT1[29:0], ph_addr == dmt_pkg::IDX_CNT0[29:0]};
	assign hit_cor = {ph_addr == dmt_pkg::IDX_COR1[29:0], ph_addr == dmt_pkg::IDX_COR0[29:0]};

	// Unmapped addresses read zero and ignore writes
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_start) begin
			rd_mux = {30'h0, run}; // [RULE9]
		end else if (hit_csr[0]) begin
			rd_mux = {16'h0000, csr[0]};
		end else if (hit_csr[1]) begin
			rd_mux = {16'h0000, csr[1]};
		end else if (hit_cnt[0]) begin
			rd_mux = {16'h0000, cnt[0]};
		end else if (hit_cnt[1]) begin
			rd_mux = {16'h0000, cnt[1]};
		end else if (hit_cor[0]) begin
			rd_mux = {16'h0000, cor[0]};
		end else if (hit_cor[1]) begin
			rd_mux = {16'h0000, cor[1]};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_load && !ph_write) begin
			hrdata <= rd_mux;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run <= dmt_pkg::START_RST;
		end else if (standby || manual_rst) begin
			run <= dmt_pkg::START_RST; // [RULE11]
		end else if (commit && hit_start && be[0]) begin
			run <= hwdata[dmt_pkg::START_RUN_HI:0]; // [RULE3]
		end
	end

	// Shared free-running prescaler
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc <= dmt_pkg::PRESC_RST;
		end else if (standby) begin
			presc <= dmt_pkg::PRESC_RST;
		end else begin
			presc <= presc + 9'h001;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tick
			assign ticks[gi] = &(presc | ~dmt_pkg::TICK_MASK[gi]); // [RULE2]
		end
		for (gi = 0; gi < 2; gi++) begin : g_ch
			dmt_channel u_ch ( // [RULE1]
				.clk(clk),
				.sys_rst(sys_rst),
				.standby(standby),
				.manual_rst(manual_rst),
				.run(run[gi]),
				.ticks(ticks),
				.csr_be((commit && hit_csr[gi]) ? be : 2'b00),
				.cnt_be((commit && hit_cnt[gi]) ? be : 2'b00),
				.cor_be((commit && hit_cor[gi]) ? be : 2'b00),
				.wdata(hwdata[15:0]),
				.flag_read(rd_load && !ph_write && hit_csr[gi] && csr[gi][dmt_pkg::CSR_FLAG_BIT]),
				.count(cnt[gi]),
				.constant(cor[gi]),
				.csr(csr[gi]),
				.match(match[gi]),
				.irq(match_irq[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_wr_cnt0;
		commit && hit_cnt[0];
	endsequence

	sequence s_wr_csr0;
		commit && hit_csr[0] && be[0];
	endsequence

	sequence s_long_phase;
		!hreadyout [*7] ##1 hreadyout;
	endsequence

	sequence s_short_phase;
		!hreadyout [*3] ##1 hreadyout;
	endsequence

	property p_long_access;
		capture && !(hsize == dmt_pkg::HSIZE_BYTE || hsize == dmt_pkg::HSIZE_HALF) |=> s_long_phase;
	endproperty
	a_long_access: assert property (p_long_access) else $error("word access latency wrong"); // [RULE14]

	property p_short_access;
		capture && (hsize == dmt_pkg::HSIZE_BYTE || hsize == dmt_pkg::HSIZE_HALF) |=> s_short_phase;
	endproperty
	a_short_access: assert property (p_short_access) else $error("byte access latency wrong"); // [RULE14]

	property p_start_rsv;
		hreadyout && $past(rd_load) && $past(hit_start) && !$past(ph_write) |-> hrdata[31:2] == 30'h0;
	endproperty
	a_start_rsv: assert property (p_start_rsv) else $error("start reserved bits not zero"); // [RULE9]

	property p_csr_rsv;
		hreadyout && $past(rd_load) && $past(hit_csr[0]) && !$past(ph_write)
			|-> hrdata[31:8] == 24'h0 && hrdata[5:2] == 4'h0;
	endproperty
	a_csr_rsv: assert property (p_csr_rsv) else $error("status reserved bits not zero"); // [RULE10]

	property p_match_clear;
		match[0] && !standby |=> cnt[0] == dmt_pkg::CNT_MATCH_VAL && csr[0][dmt_pkg::CSR_FLAG_BIT];
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("match did not clear and flag"); // [RULE5] [RULE16]

	property p_no_early_match;
		cnt[0] == cor[0] && !ticks[csr[0][1:0]] |-> !match[0];
	endproperty
	a_no_early_match: assert property (p_no_early_match) else $error("match without tick"); // [RULE15]

	property p_increment;
		run[0] && ticks[csr[0][1:0]] && !match[0] && !(commit && hit_cnt[0] && |be) && !standby
			|=> cnt[0] == $past(cnt[0]) + 16'h0001;
	endproperty
	a_increment: assert property (p_increment) else $error("counter missed a tick"); // [RULE4]

	property p_halted;
		!run[0] && !(commit && hit_cnt[0]) && !standby |=> $stable(cnt[0]);
	endproperty
	a_halted: assert property (p_halted) else $error("halted counter moved"); // [RULE19] [RULE3]

	property p_word_write;
		s_wr_cnt0 ##0 (be == 2'b11 && !match[0] && !standby) |=> cnt[0] == $past(hwdata[15:0]);
	endproperty
	a_word_write: assert property (p_word_write) else $error("word write lost to increment"); // [RULE17]

	property p_byte_write;
		s_wr_cnt0 ##0 (be == 2'b01 && !match[0] && !standby)
			|=> cnt[0][7:0] == $past(hwdata[7:0]) && cnt[0][15:8] == $past(cnt[0][15:8]);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write disturbed other byte"); // [RULE18]

	property p_flag_sticky;
		csr[0][dmt_pkg::CSR_FLAG_BIT] && !(commit && hit_csr[0] && be[0]) && !standby && !manual_rst
			|=> csr[0][dmt_pkg::CSR_FLAG_BIT];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write"); // [RULE7]

	property p_irq_hold;
		match_irq[0] && !(commit && hit_csr[0]) && !standby && !manual_rst |=> match_irq[0];
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early"); // [RULE20] [RULE6]

	property p_irq_rise;
		match[0] && csr[0][dmt_pkg::CSR_IE_BIT] && !standby && !manual_rst && !(commit && hit_csr[0])
			|=> match_irq[0];
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt not raised on match"); // [RULE6] [RULE8]

	property p_standby_init;
		standby |=> run == 2'b00 && cnt[0] == dmt_pkg::CNT_RST && cor[0] == dmt_pkg::COR_RST
			&& csr[0] == 16'h0000;
	endproperty
	a_standby_init: assert property (p_standby_init) else $error("standby did not initialise"); // [RULE11] [RULE13]

	property p_manual_keep;
		manual_rst && !standby && !match[0] && !(commit && (hit_cnt[0] || hit_cor[0]))
			|=> $stable(cor[0]) && (cnt[0] == $past(cnt[0]) || cnt[0] == $past(cnt[0]) + 16'h0001);
	endproperty
	a_manual_keep: assert property (p_manual_keep) else $error("manual reset touched counter"); // [RULE12]

	property p_run_write;
		commit && hit_start && be[0] && !standby && !manual_rst |=> run == $past(hwdata[dmt_pkg::START_RUN_HI:0]);
	endproperty
	a_run_write: assert property (p_run_write) else $error("run bits not taken from write"); // [RULE3]

	property p_ch1_tick_only;
		!ticks[csr[1][1:0]] && !(commit && hit_cnt[1]) && !standby |=> $stable(cnt[1]);
	endproperty
	a_ch1_tick_only: assert property (p_ch1_tick_only) else $error("counter moved off its tick"); // [RULE2]

	property p_flag_write_one;
		s_wr_csr0 ##0 (hwdata[dmt_pkg::CSR_FLAG_BIT] && csr[0][dmt_pkg::CSR_FLAG_BIT] && !standby && !manual_rst)
			|=> csr[0][dmt_pkg::CSR_FLAG_BIT];
	endproperty
	a_flag_write_one: assert property (p_flag_write_one) else $error("writing one disturbed flag"); // [RULE7]
endmodule : dmt_timer

// >>> dv/dmt_cpu_host.sv
`timescale 1ns/10ps
module dmt_cpu_host (
	// Clock
	input wire logic clk,
	// Master request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Slave answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
	end

	// Caller is at a rising edge; returns at the edge that ends the data phase
	task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] d,
		output logic [31:0] q, output int n);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= s;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		// Released lines flip so stale values cannot pass for live ones
		haddr <= ~a;
		hwdata <= w ? d : ~d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask : xfer
endmodule : dmt_cpu_host

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic clk;
	logic sys_rst;
	logic standby;
	logic manual_rst;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [1:0] match_irq;
	logic [31:0] q;
	int lat;
	int errors;
	int check_count;

	dmt_timer i_dmt_timer (.clk(clk), .sys_rst(sys_rst), .standby(standby), .manual_rst(manual_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .match_irq(match_irq));
	dmt_cpu_host i_dmt_cpu_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] ad(input logic [31:0] idx);
		return {idx[29:0], 2'h0};
	endfunction : ad

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] idx, input logic [15:0] d);
		i_dmt_cpu_host.xfer(ad(idx), 1'b1, dmt_pkg::HSIZE_HALF, {16'h0000, d}, q, lat);
	endtask : wr

	task automatic rd(input logic [31:0] idx, input logic [15:0] e);
		i_dmt_cpu_host.xfer(ad(idx), 1'b0, dmt_pkg::HSIZE_HALF, 32'h0, q, lat);
		chk(q, {16'h0000, e});
	endtask : rd

	// Plain read into q, judged by the caller
	task automatic rdq(input logic [31:0] idx);
		i_dmt_cpu_host.xfer(ad(idx), 1'b0, dmt_pkg::HSIZE_HALF, 32'h0, q, lat);
	endtask : rdq

	task automatic test_reset;
		rd(dmt_pkg::IDX_START, 16'h0000);
		rd(dmt_pkg::IDX_CSR0, 16'h0000);
		rd(dmt_pkg::IDX_CNT0, 16'h0000);
		rd(dmt_pkg::IDX_COR0, 16'hFFFF);
		rd(dmt_pkg::IDX_CSR1, 16'h0000);
		rd(dmt_pkg::IDX_CNT1, 16'h0000);
		rd(dmt_pkg::IDX_COR1, 16'hFFFF);
		i_dmt_cpu_host.xfer(32'hFFFFDC44, 1'b0, dmt_pkg::HSIZE_HALF, 32'h0, q, lat);
		chk(q, 32'h0);
		chk({31'h0, hresp}, 32'h0);
	endtask : test_reset

	task automatic test_reserved;
		wr(dmt_pkg::IDX_START, 16'h0003);
		rd(dmt_pkg::IDX_START, 16'h0003);
		wr(dmt_pkg::IDX_START, 16'h0000);
		wr(dmt_pkg::IDX_CSR1, 16'h00C3);
		rd(dmt_pkg::IDX_CSR1, 16'h0043);
		wr(dmt_pkg::IDX_CSR1, 16'h0000);
		// Channel 0 ran a few ticks above; start the byte test from zero
		wr(dmt_pkg::IDX_CNT0, 16'h0000);
	endtask : test_reserved

	task automatic test_access;
		chk(lat, dmt_pkg::ACC_SHORT_CYC);
		i_dmt_cpu_host.xfer(ad(dmt_pkg::IDX_CNT0) + 32'h1, 1'b1, dmt_pkg::HSIZE_BYTE, 32'h0000AB00, q, lat);
		chk(lat, dmt_pkg::ACC_SHORT_CYC);
		rd(dmt_pkg::IDX_CNT0, 16'hAB00);
		i_dmt_cpu_host.xfer(ad(dmt_pkg::IDX_COR0), 1'b1, 3'h2, 32'h00001234, q, lat);
		chk(lat, dmt_pkg::ACC_LONG_CYC);
		rd(dmt_pkg::IDX_COR0, 16'h1234);
	endtask : test_access

	task automatic test_match;
		logic [15:0] held;
		wr(dmt_pkg::IDX_COR0, 16'h0002);
		wr(dmt_pkg::IDX_CNT0, 16'h0000);
		wr(dmt_pkg::IDX_CSR0, 16'h0040);
		wr(dmt_pkg::IDX_START, 16'h0001);
		for (int i = 0; i < 400 && match_irq[0] !== 1'b1; i++) @(posedge clk);
		chk(match_irq, 2'h1);
		wr(dmt_pkg::IDX_START, 16'h0000);
		rdq(dmt_pkg::IDX_CNT0);
		// Counter wraps at the constant, so it never passes it
		chk({31'h0, q[15:0] > 16'h0002}, 32'h0);
		held = q[15:0];
		// No flag read yet, so this zero must not clear it
		wr(dmt_pkg::IDX_CSR0, 16'h0040);
		@(posedge clk);
		chk(match_irq, 2'h1);
		rd(dmt_pkg::IDX_CSR0, 16'h00C0);
		wr(dmt_pkg::IDX_CSR0, 16'h0080);
		// Enable drops at the commit edge; look once it has settled
		@(posedge clk);
		chk(match_irq, 2'h0);
		rd(dmt_pkg::IDX_CSR0, 16'h0080);
		wr(dmt_pkg::IDX_CSR0, 16'h0000);
		rd(dmt_pkg::IDX_CSR0, 16'h0000);
		repeat (600) @(posedge clk);
		rd(dmt_pkg::IDX_CNT0, held);
	endtask : test_match

	task automatic test_select;
		logic [15:0] e;
		for (int k = 0; k < 4; k++) begin
			wr(dmt_pkg::IDX_CSR1, 16'(k));
			wr(dmt_pkg::IDX_CNT1, 16'h0000);
			wr(dmt_pkg::IDX_START, 16'h0002);
			repeat (2048) @(posedge clk);
			wr(dmt_pkg::IDX_START, 16'h0000);
			rdq(dmt_pkg::IDX_CNT1);
			e = 16'(2048 >> (3 + 2 * k));
			// Free prescaler phase leaves up to two ticks of slack
			chk({31'h0, (q[15:0] + 16'h0001 < e) || (q[15:0] > e + 16'h0002)}, 32'h0);
		end
	endtask : test_select

	task automatic test_resets;
		wr(dmt_pkg::IDX_CNT0, 16'h1234);
		wr(dmt_pkg::IDX_COR0, 16'h0055);
		wr(dmt_pkg::IDX_CSR0, 16'h0041);
		manual_rst <= 1'b1;
		@(posedge clk);
		manual_rst <= 1'b0;
		@(posedge clk);
		rd(dmt_pkg::IDX_CSR0, 16'h0000);
		rd(dmt_pkg::IDX_CNT0, 16'h1234);
		rd(dmt_pkg::IDX_COR0, 16'h0055);
		wr(dmt_pkg::IDX_START, 16'h0002);
		standby <= 1'b1;
		@(posedge clk);
		standby <= 1'b0;
		@(posedge clk);
		rd(dmt_pkg::IDX_START, 16'h0000);
		rd(dmt_pkg::IDX_CNT0, 16'h0000);
		rd(dmt_pkg::IDX_COR0, 16'hFFFF);
	endtask : test_resets

	task automatic complete_run;
		$display("Checks %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		errors = 0;
		check_count = 0;
		sys_rst = 1'b1;
		standby = 1'b0;
		manual_rst = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		test_reset();
		test_reserved();
		test_access();
		test_match();
		test_select();
		test_resets();
		complete_run();
	end
endmodule : tb
